//--- rtl/atc_pkg.sv
// Constants for the analog trim configuration register bank.
// Assumes a 32-bit Avalon-MM bus with byte addresses; each register uses one word.
package atc_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [7:0] IDX_RANGE_A = 8'h30;
	localparam logic [7:0] IDX_RANGE_B = 8'h32;
	localparam logic [7:0] IDX_BYPASS = 8'h38;
	localparam logic [7:0] IDX_TS_CTRL = 8'h3B;
	localparam logic [7:0] IDX_PREEMPH = 8'h48;
	localparam int ADDR_W = 10;
	localparam int IDX_LSB = 2;
	// Values after reset
	localparam logic [15:0] RST_RANGE = 16'hA000;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
	// Field positions
	localparam int BIT_BYPASS = 0;
	localparam int BIT_TS_EN = 0;
	localparam int BIT_TS_PECL = 1;
	localparam int PE_MSB = 3;
	localparam int PE_W = 4;
	localparam int NUM_LANES = 16;
	// Full-scale code to millivolt mapping points
	localparam logic [15:0] FS_CODE_MIN = 16'h2000;
	localparam logic [15:0] FS_CODE_DEF = 16'hA000;
	localparam logic [15:0] FS_CODE_MAX = 16'hFFFF;
	localparam logic [10:0] MV_AT_MIN = 11'd500;
	localparam logic [10:0] MV_AT_DEF = 11'd800;
	localparam logic [10:0] MV_AT_MAX = 11'd1000;
	localparam int FS_LO_SHIFT = 15;
	localparam logic [23:0] FS_HI_CODES = 24'd24575;
	// Bus answer: cycles of waitrequest before each access is taken
	localparam int BUS_WAIT_CYCLES = 1;
endpackage

//--- rtl/atc_avmm_slv.sv
// Avalon-MM handshake for the register bank: one wait cycle per access.
// Assumes the master holds its request until it sees waitrequest low.
`timescale 1ns/1ns
`default_nettype none
module atc_avmm_slv (
	input wire logic clk, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic read, // Avalon read request
	input wire logic write, // Avalon write request
	output logic waitrequest, // Stall while answer not ready
	output logic take, // Access accepted this cycle
	output logic load // First cycle of an access
);
	import atc_pkg::*;
	logic ack_ff;
	logic nxt_ack;

	// Acknowledge one cycle after a request is seen
	assign nxt_ack = (read | write) & ~ack_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= nxt_ack;
		end
	end

	// Handshake outputs
	assign waitrequest = (read | write) & ~ack_ff;
	assign take = (read | write) & ack_ff;
	assign load = nxt_ack;

	property p_wait_bound;
		@(posedge clk) disable iff (!rst_n)
		(read | write) |-> ##[0:1] !waitrequest;
	endproperty
	a_wait_bound: assert property (p_wait_bound) else $error("waitrequest held too long");
endmodule
`default_nettype wire

//--- rtl/atc_fs_scale.sv
// Full-scale code to nominal range in millivolts, piecewise linear.
// Assumes the code input is a stored register value.
`timescale 1ns/1ns
`default_nettype none
module atc_fs_scale (
	input wire logic clk, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [15:0] code, // Full-scale code
	output logic [10:0] range_mv_ff, // Nominal range in mVpp
	output logic below_min_ff // Code under recommended minimum
);
	import atc_pkg::*;
	logic signed [17:0] lo_diff;
	logic signed [27:0] lo_prod;
	logic signed [27:0] lo_mv;
	logic [15:0] hi_diff;
	logic [23:0] hi_prod;
	logic [23:0] hi_quot;
	logic [10:0] nxt_range_mv;

	// Two segments: min..default spans 300 mV, default..max spans 200 mV
	always_comb begin
		lo_diff = $signed({2'b00, code}) - $signed({2'b00, FS_CODE_MIN});
		lo_prod = lo_diff * 28'sd300;
		lo_mv = 28'sd500 + (lo_prod >>> FS_LO_SHIFT);
		hi_diff = code - FS_CODE_DEF;
		hi_prod = {8'h00, hi_diff} * 24'd200;
		hi_quot = hi_prod / FS_HI_CODES;
		if (code < FS_CODE_DEF) begin
			nxt_range_mv = lo_mv[10:0];
		end else begin
			nxt_range_mv = MV_AT_DEF + hi_quot[10:0];
		end
	end

	// Register the result
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			range_mv_ff <= MV_AT_DEF;
			below_min_ff <= 1'b0;
		end else begin
			range_mv_ff <= nxt_range_mv;
			below_min_ff <= code < FS_CODE_MIN;
		end
	end

	property p_map_points;
		@(posedge clk) disable iff (!rst_n)
		(code == FS_CODE_MIN) |=> (range_mv_ff == MV_AT_MIN);
	endproperty
	a_map_points: assert property (p_map_points) else $error("minimum code not 500 mV");
	property p_map_ends;
		@(posedge clk) disable iff (!rst_n)
		((code == FS_CODE_DEF) |=> (range_mv_ff == MV_AT_DEF))
		and ((code == FS_CODE_MAX) |=> (range_mv_ff == MV_AT_MAX));
	endproperty
	a_map_ends: assert property (p_map_ends) else $error("default or max code mapped wrong");
endmodule
`default_nettype wire

//--- rtl/atc_regs.sv
// Analog trim configuration register bank: range codes, reference bypass,
// timestamp input controls and lane pre-emphasis, over Avalon-MM.
// Assumes one clock, asynchronous active-low reset, a master that holds requests.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Input A range code, 16 bits RW, resets 0xA000, drives input A range control.
// - Input B range code, independent, 16 bits RW, resets 0xA000, drives input B.
// - Codes map 0x2000 to 500 mV, 0xA000 to 800 mV, 0xFFFF to 1000 mV.
// - Bypass bit 0, reset 0, selects core supply as reference when set.
// - Timestamp control bit 0, reset 0, enables the timestamp input receiver.
// - Timestamp control bit 1, reset 0, selects low-voltage PECL signalling.
// - Pre-emphasis bits 3..0, reset 0, one setting for all 16 lanes.
module atc_regs #(
	parameter int LANES = atc_pkg::NUM_LANES // Serial output lanes
) (
	input wire logic clk, // System clock, 25 MHz
	input wire logic rst_n, // Async reset, active low
	input wire logic [atc_pkg::ADDR_W-1:0] address, // Byte address
	input wire logic read, // Read request
	input wire logic write, // Write request
	input wire logic [31:0] writedata, // Write data
	input wire logic [3:0] byteenable, // Byte lanes
	output logic [31:0] readdata, // Read data
	output logic waitrequest, // Stall
	output logic [15:0] input_a_fullscale_code, // Input A range control
	output logic [15:0] input_b_fullscale_code, // Input B range control
	output logic [10:0] input_a_range_mv, // Input A nominal mVpp
	output logic [10:0] input_b_range_mv, // Input B nominal mVpp
	output logic input_a_below_min, // Input A code under minimum
	output logic input_b_below_min, // Input B code under minimum
	output logic reference_bypass_select, // Core supply as reference
	output logic timestamp_receiver_enable, // Timestamp receiver on
	output logic timestamp_pecl_mode, // Timestamp LVPECL mode
	output logic [LANES*atc_pkg::PE_W-1:0] lane_preemphasis // Per-lane pre-emphasis
);
	import atc_pkg::*;

	logic [15:0] range_a_ff;
	logic [15:0] range_b_ff;
	logic [7:0] bypass_ff;
	logic [7:0] ts_ctrl_ff;
	logic [7:0] preemph_ff;
	logic [31:0] readdata_ff;
	logic [31:0] nxt_readdata;
	logic take;
	logic load;
	logic wr_take;
	logic rd_take;

	// Index match on a byte address
	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		hit = (addr[ADDR_W-1:IDX_LSB] == idx) && (addr[IDX_LSB-1:0] == 2'b00);
	endfunction

	// Merge enabled low byte lanes into a stored value
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] be);
		merge[7:0] = be[0] ? wd[7:0] : old[7:0];
		merge[15:8] = be[1] ? wd[15:8] : old[15:8];
	endfunction

	// Bus handshake
	atc_avmm_slv u_slv (
		.clk(clk),
		.rst_n(rst_n),
		.read(read),
		.write(write),
		.waitrequest(waitrequest),
		.take(take),
		.load(load)
	);

	assign wr_take = take & write;
	assign rd_take = take & read;

	// Input A range code
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			range_a_ff <= RST_RANGE;
		end else if (wr_take && hit(address, IDX_RANGE_A)) begin
			range_a_ff <= merge(range_a_ff, writedata[15:0], byteenable[1:0]);
		end
	end

	// Input B range code
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			range_b_ff <= RST_RANGE;
		end else if (wr_take && hit(address, IDX_RANGE_B)) begin
			range_b_ff <= merge(range_b_ff, writedata[15:0], byteenable[1:0]);
		end
	end

	// Reference bypass, whole byte kept
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bypass_ff <= RST_BYTE;
		end else if (wr_take && hit(address, IDX_BYPASS) && byteenable[0]) begin
			bypass_ff <= writedata[7:0];
		end
	end

	// Timestamp input control, whole byte kept
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ts_ctrl_ff <= RST_BYTE;
		end else if (wr_take && hit(address, IDX_TS_CTRL) && byteenable[0]) begin
			ts_ctrl_ff <= writedata[7:0];
		end
	end

	// Lane pre-emphasis, whole byte kept
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			preemph_ff <= RST_BYTE;
		end else if (wr_take && hit(address, IDX_PREEMPH) && byteenable[0]) begin
			preemph_ff <= writedata[7:0];
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		nxt_readdata = RD_UNMAPPED;
		if (hit(address, IDX_RANGE_A)) begin
			nxt_readdata = {16'h0000, range_a_ff};
		end else if (hit(address, IDX_RANGE_B)) begin
			nxt_readdata = {16'h0000, range_b_ff};
		end else if (hit(address, IDX_BYPASS)) begin
			nxt_readdata = {24'h000000, bypass_ff};
		end else if (hit(address, IDX_TS_CTRL)) begin
			nxt_readdata = {24'h000000, ts_ctrl_ff};
		end else if (hit(address, IDX_PREEMPH)) begin
			nxt_readdata = {24'h000000, preemph_ff};
		end
	end

	// Capture read data in the wait cycle so it stands when accepted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata_ff <= RD_UNMAPPED;
		end else if (load && read) begin
			readdata_ff <= nxt_readdata;
		end
	end
	assign readdata = readdata_ff;

	// Analog and serializer controls straight from storage
	assign input_a_fullscale_code = range_a_ff;
	assign input_b_fullscale_code = range_b_ff;
	assign reference_bypass_select = bypass_ff[BIT_BYPASS];
	assign timestamp_receiver_enable = ts_ctrl_ff[BIT_TS_EN];
	assign timestamp_pecl_mode = ts_ctrl_ff[BIT_TS_PECL];
	assign lane_preemphasis = {LANES{preemph_ff[PE_MSB:0]}};

	// Nominal range readouts; low codes flagged, never blocked
	atc_fs_scale u_scale_a (
		.clk(clk),
		.rst_n(rst_n),
		.code(range_a_ff),
		.range_mv_ff(input_a_range_mv),
		.below_min_ff(input_a_below_min)
	);
	atc_fs_scale u_scale_b (
		.clk(clk),
		.rst_n(rst_n),
		.code(range_b_ff),
		.range_mv_ff(input_b_range_mv),
		.below_min_ff(input_b_below_min)
	);

	// Checks on the register behaviour
	property p_range_a_write;
		@(posedge clk) disable iff (!rst_n)
		(wr_take && hit(address, IDX_RANGE_A) && byteenable[1:0] == 2'b11)
		|=> (input_a_fullscale_code == $past(writedata[15:0]));
	endproperty
	a_range_a_write: assert property (p_range_a_write) else $error("A code not stored");

	property p_range_a_hold;
		@(posedge clk) disable iff (!rst_n)
		!(wr_take && hit(address, IDX_RANGE_A)) |=> $stable(input_a_fullscale_code);
	endproperty
	a_range_a_hold: assert property (p_range_a_hold) else $error("A code changed");

	property p_range_b_indep;
		@(posedge clk) disable iff (!rst_n)
		(wr_take && hit(address, IDX_RANGE_A)) |=> $stable(input_b_fullscale_code);
	endproperty
	a_range_b_indep: assert property (p_range_b_indep) else $error("B code hit by A");

	property p_range_b_write;
		@(posedge clk) disable iff (!rst_n)
		(wr_take && hit(address, IDX_RANGE_B) && byteenable[1:0] == 2'b11)
		|=> (input_b_fullscale_code == $past(writedata[15:0]));
	endproperty
	a_range_b_write: assert property (p_range_b_write) else $error("B code not stored");

	property p_bypass_write;
		@(posedge clk) disable iff (!rst_n)
		(wr_take && hit(address, IDX_BYPASS) && byteenable[0])
		|=> (reference_bypass_select == $past(writedata[BIT_BYPASS]));
	endproperty
	a_bypass_write: assert property (p_bypass_write) else $error("bypass not set");

	property p_ts_enable;
		@(posedge clk) disable iff (!rst_n)
		(wr_take && hit(address, IDX_TS_CTRL) && byteenable[0])
		|=> (timestamp_receiver_enable == $past(writedata[BIT_TS_EN]))
		##1 $stable(timestamp_receiver_enable) || $past(wr_take);
	endproperty
	a_ts_enable: assert property (p_ts_enable) else $error("receiver enable wrong");

	property p_ts_pecl;
		@(posedge clk) disable iff (!rst_n)
		(wr_take && hit(address, IDX_TS_CTRL) && byteenable[0])
		|=> (timestamp_pecl_mode == $past(writedata[BIT_TS_PECL]));
	endproperty
	a_ts_pecl: assert property (p_ts_pecl) else $error("PECL mode wrong");

	property p_preemph_lanes;
		@(posedge clk) disable iff (!rst_n)
		(wr_take && hit(address, IDX_PREEMPH) && byteenable[0])
		|=> (lane_preemphasis[PE_W-1:0] == $past(writedata[PE_MSB:0]))
		&& (lane_preemphasis[LANES*PE_W-1 -: PE_W] == $past(writedata[PE_MSB:0]));
	endproperty
	a_preemph_lanes: assert property (p_preemph_lanes) else $error("lanes not common");

	property p_reserved_readback;
		@(posedge clk) disable iff (!rst_n)
		(rd_take && hit(address, IDX_TS_CTRL))
		|-> (readdata == {24'h000000, ts_ctrl_ff});
	endproperty
	a_reserved_readback: assert property (p_reserved_readback) else $error("readback wrong");

	property p_unmapped_zero;
		@(posedge clk) disable iff (!rst_n)
		(rd_take && !hit(address, IDX_RANGE_A) && !hit(address, IDX_RANGE_B)
		&& !hit(address, IDX_BYPASS) && !hit(address, IDX_TS_CTRL)
		&& !hit(address, IDX_PREEMPH)) |-> (readdata == RD_UNMAPPED);
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped not zero");

	// Storage still at reset values on the first edge after release
	property p_reset_values;
		@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> (range_a_ff == RST_RANGE) && (range_b_ff == RST_RANGE)
		&& (bypass_ff == RST_BYTE) && (ts_ctrl_ff == RST_BYTE) && (preemph_ff == RST_BYTE);
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

	property p_range_a_lane;
		@(posedge clk) disable iff (!rst_n)
		(wr_take && hit(address, IDX_RANGE_A) && byteenable[1:0] == 2'b01)
		|=> (input_a_fullscale_code == {$past(range_a_ff[15:8]), $past(writedata[7:0])});
	endproperty
	a_range_a_lane: assert property (p_range_a_lane) else $error("A lane wrong");

	property p_range_b_hold;
		@(posedge clk) disable iff (!rst_n)
		!(wr_take && hit(address, IDX_RANGE_B)) |=> $stable(input_b_fullscale_code);
	endproperty
	a_range_b_hold: assert property (p_range_b_hold) else $error("B code changed");

	property p_bypass_hold;
		@(posedge clk) disable iff (!rst_n)
		!(wr_take && hit(address, IDX_BYPASS)) |=> $stable(bypass_ff);
	endproperty
	a_bypass_hold: assert property (p_bypass_hold) else $error("bypass byte changed");

	property p_ts_hold;
		@(posedge clk) disable iff (!rst_n)
		!(wr_take && hit(address, IDX_TS_CTRL)) |=> $stable(ts_ctrl_ff);
	endproperty
	a_ts_hold: assert property (p_ts_hold) else $error("timestamp byte changed");

	property p_preemph_hold;
		@(posedge clk) disable iff (!rst_n)
		!(wr_take && hit(address, IDX_PREEMPH)) |=> $stable(preemph_ff);
	endproperty
	a_preemph_hold: assert property (p_preemph_hold) else $error("pre-emphasis changed");

	property p_bypass_readback;
		@(posedge clk) disable iff (!rst_n)
		(rd_take && hit(address, IDX_BYPASS))
		|-> (readdata == {24'h000000, bypass_ff});
	endproperty
	a_bypass_readback: assert property (p_bypass_readback) else $error("bypass readback");

	// Main scenarios
	property p_cov_low_code;
		@(posedge clk) disable iff (!rst_n)
		wr_take && hit(address, IDX_RANGE_A) && writedata[15:0] < FS_CODE_MIN;
	endproperty
	c_cov_low_code: cover property (p_cov_low_code);
	property p_cov_ts_both;
		@(posedge clk) disable iff (!rst_n)
		timestamp_receiver_enable && timestamp_pecl_mode;
	endproperty
	c_cov_ts_both: cover property (p_cov_ts_both);
	property p_cov_back_to_back;
		@(posedge clk) disable iff (!rst_n)
		wr_take ##1 (read && waitrequest) ##1 rd_take;
	endproperty
	c_cov_back_to_back: cover property (p_cov_back_to_back);
endmodule
`default_nettype wire

//--- test/atc_regs_tb_top.sv
// Self-checking bench for the analog trim register bank over Avalon-MM.
// Assumes one 25 MHz clock, active-low async reset, one wait cycle per access.
`timescale 1ns/1ns
`default_nettype none
module atc_regs_tb_top;
	import atc_pkg::*;
	localparam logic [9:0] A_RA = {IDX_RANGE_A, 2'b00};
	localparam logic [9:0] A_RB = {IDX_RANGE_B, 2'b00};
	localparam logic [9:0] A_BP = {IDX_BYPASS, 2'b00};
	localparam logic [9:0] A_TS = {IDX_TS_CTRL, 2'b00};
	localparam logic [9:0] A_PE = {IDX_PREEMPH, 2'b00};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] address = '0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = '0;
	logic [3:0] byteenable = '0;
	logic [31:0] readdata;
	logic waitrequest;
	logic [15:0] code_a, code_b;
	logic [10:0] mv_a, mv_b;
	logic low_a, low_b, bypass, ts_en, ts_pecl;
	logic [NUM_LANES*PE_W-1:0] lanes;
	int n_mismatch = 0;
	int checked = 0;

	atc_regs #(.LANES(NUM_LANES)) i_atc_regs (.clk(clk), .rst_n(rst_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .input_a_fullscale_code(code_a),
		.input_b_fullscale_code(code_b), .input_a_range_mv(mv_a), .input_b_range_mv(mv_b),
		.input_a_below_min(low_a), .input_b_below_min(low_b),
		.reference_bypass_select(bypass), .timestamp_receiver_enable(ts_en),
		.timestamp_pecl_mode(ts_pecl), .lane_preemphasis(lanes));

	// Free-running 25 MHz clock
	always #20 clk = ~clk;

	// Compare and count
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One access, held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		writedata <= d;
		byteenable <= be;
		write <= wr;
		read <= ~wr;
		@(posedge clk);
		while (waitrequest !== 1'b0 && n < 20) begin
			n++;
			@(posedge clk);
		end
		if (n >= 20) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, waitrequest, 1'b0);
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] q;
		bus(1'b1, a, d, be, q);
		repeat (2) @(negedge clk);
	endtask

	task automatic rd(input logic [9:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, 4'hF, q);
		chk({32'h0, q}, {32'h0, e});
	endtask

	// Reset values at the outputs and on readback
	task automatic t_reset;
		chk(code_a, RST_RANGE);
		chk(code_b, RST_RANGE);
		chk(mv_a, 11'h320);
		chk(mv_b, 11'h320);
		chk({low_a, low_b}, 2'h0);
		chk({bypass, ts_en, ts_pecl}, 3'h0);
		chk(lanes, '0);
		rd(A_RA, 32'h0000_A000);
		rd(A_RB, 32'h0000_A000);
		rd(A_BP, 32'h0000_0000);
		rd(A_TS, 32'h0000_0000);
		rd(A_PE, 32'h0000_0000);
	endtask

	// Independent range codes and the mapping points
	task automatic t_range;
		wr(A_RA, 32'hFFFF_2000, 4'hF);
		wr(A_RB, 32'h0000_FFFF, 4'hF);
		chk(code_a, 16'h2000);
		chk(code_b, 16'hFFFF);
		chk(mv_a, 11'h1F4);
		chk(mv_b, 11'h3E8);
		rd(A_RA, 32'h0000_2000);
		wr(A_RA, 32'h0000_A000, 4'h3);
		chk(mv_a, 11'h320);
		chk(code_b, 16'hFFFF);
		rd(A_RB, 32'h0000_FFFF);
	endtask

	// Codes under the minimum are stored; byte-lane write
	task automatic t_low;
		wr(A_RB, 32'h0000_0000, 4'hF);
		chk(code_b, 16'h0000);
		chk(low_b, 1'b1);
		chk(mv_b, 11'h1A9);
		wr(A_RB, 32'h0000_2000, 4'hF);
		chk(low_b, 1'b0);
		wr(A_RA, 32'h0000_1FFF, 4'hF);
		chk(low_a, 1'b1);
		chk(mv_a, 11'h1F3);
		wr(A_RA, 32'hFFFF_A000, 4'h2);
		chk(code_a, 16'hA0FF);
		wr(A_RA, 32'hFFFF_1234, 4'h1);
		chk(code_a, 16'hA034);
		rd(A_RA, 32'h0000_A034);
	endtask

	// Single-bit controls, reserved bits and lane pre-emphasis
	task automatic t_bits;
		logic [1:0] v;
		wr(A_BP, 32'h0000_00FF, 4'h1);
		chk(bypass, 1'b1);
		rd(A_BP, 32'h0000_00FF);
		wr(A_BP, 32'h0000_00FE, 4'h1);
		chk(bypass, 1'b0);
		for (int i = 0; i < 4; i++) begin
			v = i[1:0];
			wr(A_TS, {24'h0, 6'h2A, v}, 4'h1);
			chk(ts_en, v[0]);
			chk(ts_pecl, v[1]);
			rd(A_TS, {24'h0, 6'h2A, v});
		end
		wr(A_PE, 32'h0000_00C5, 4'h1);
		chk(lanes, {NUM_LANES{4'h5}});
		rd(A_PE, 32'h0000_00C5);
		wr(A_PE, 32'h0000_000F, 4'h0);
		chk(lanes, {NUM_LANES{4'h5}});
	endtask

	// Unmapped and misaligned places do nothing and read zero
	task automatic t_unmap;
		wr(10'h0C4, 32'h0000_FFFF, 4'hF);
		rd(10'h0C4, 32'h0000_0000);
		wr(10'h0C1, 32'h0000_1111, 4'hF);
		chk(code_a, 16'hA034);
		rd(10'h0C2, 32'h0000_0000);
	endtask

	// Reset in mid-run restores defaults
	task automatic t_rerun;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk(code_a, RST_RANGE);
		chk(code_b, RST_RANGE);
		chk(mv_a, 11'h320);
		chk(lanes, '0);
		chk({bypass, ts_en, ts_pecl}, 3'h0);
		chk(readdata, 32'h0000_0000);
		rst_n <= 1'b1;
	endtask

	// Verdict and end of run
	task summarize;
		if (n_mismatch == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_range();
		t_low();
		t_bits();
		t_unmap();
		t_rerun();
		t_reset();
		summarize();
	end

	// Watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		summarize();
	end
endmodule
`default_nettype wire
